/* File: dafs_status.sv */
// Combined fault status word with event latch, mask and interrupt
//
// Local design decisions: the register offsets and the plain strobed port.
`timescale 1ns/1ps

module dafs_status (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic resetn,
    // Fault sources from checking circuits and drive
    input wire dafs_pkg::dafs_faults_t faults_in,
    // Register port
    input wire dafs_pkg::dafs_bus_req_t bus_req,
    output logic [15:0] rdata,
    // Interrupt
    output logic irq
);

    typedef struct packed {
        logic [15:0] prev;
        logic [15:0] event_flags;
        logic [15:0] mask;
        logic [15:0] rdata;
        logic irq;
    } dafs_state_t;

    dafs_state_t state_reg;
    dafs_state_t state_next;
    logic [15:0] raw_word;
    logic [15:0] live_word;
    logic [15:0] rise;
    logic [15:0] w1c;
    logic hit_status;
    logic hit_event;
    logic hit_mask;

    // The word is a fixed concatenation of the source flags
    // Bits are listed by name so a reordered carrier cannot move them
    assign raw_word = {
        faults_in.data_ecc_err,
        faults_in.id_compare_err,
        faults_in.id_ecc_err,
        faults_in.exec_fault,
        faults_in.spindle_fault,
        faults_in.seek_fault,
        faults_in.off_cyl_fault,
        faults_in.head_sel_fault,
        faults_in.double_bit_err,
        faults_in.single_bit_err,
        faults_in.v5p0_fault,
        faults_in.vn4p5_fault,
        faults_in.byte0_par_err,
        faults_in.bus_b_par_err,
        faults_in.byte1_par_err,
        faults_in.bus_a_par_err
    };

    // Sources are asynchronous to this clock
    dafs_sync #(
        .W(dafs_pkg::DATA_W)
    ) u_sync (
        .ref_clk(ref_clk),
        .resetn(resetn),
        .async_in(raw_word),
        .sync_out(live_word)
    );

    assign hit_status = (bus_req.addr == dafs_pkg::OFF_STATUS);
    assign hit_event = (bus_req.addr == dafs_pkg::OFF_EVENT);
    assign hit_mask = (bus_req.addr == dafs_pkg::OFF_MASK);
    assign rise = live_word & ~state_reg.prev;
    assign w1c = (bus_req.wr && hit_event) ? bus_req.wdata : 16'h0000;

    always_comb
    begin
        state_next = state_reg;
        state_next.prev = live_word;
        // A new fault edge wins over a clear in the same cycle
        state_next.event_flags = (state_reg.event_flags & ~w1c) | rise;
        if (bus_req.wr && hit_mask)
        begin
            state_next.mask = bus_req.wdata;
        end
        // Writes to the status word fall through with no effect
        state_next.rdata = dafs_pkg::RST_WORD;
        if (bus_req.rd)
        begin
            case (1'b1)
                hit_status: state_next.rdata = live_word;
                hit_event: state_next.rdata = state_reg.event_flags;
                hit_mask: state_next.rdata = state_reg.mask;
                default: state_next.rdata = dafs_pkg::RST_WORD;
            endcase
        end
        state_next.irq = |(state_next.event_flags & state_next.mask);
    end

    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            state_reg.prev <= dafs_pkg::RST_WORD;
            state_reg.event_flags <= dafs_pkg::RST_EVENT;
            state_reg.mask <= dafs_pkg::RST_MASK;
            state_reg.rdata <= dafs_pkg::RST_WORD;
            state_reg.irq <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    assign rdata = state_reg.rdata;
    assign irq = state_reg.irq;

    // Status reads return each source as seen two edges before the read
    logic st_rd;
    assign st_rd = bus_req.rd && hit_status;

    property p_bit0;
        @(posedge ref_clk) disable iff (!resetn)
        st_rd |=> rdata[0] == $past(faults_in.bus_a_par_err, 3);
    endproperty
    a_bit0: assert property (p_bit0) else $error("bit 0 wrong");

    property p_bit1;
        @(posedge ref_clk) disable iff (!resetn)
        st_rd |=> rdata[1] == $past(faults_in.byte1_par_err, 3);
    endproperty
    a_bit1: assert property (p_bit1) else $error("bit 1 wrong");

    property p_bit2;
        @(posedge ref_clk) disable iff (!resetn)
        st_rd |=> rdata[2] == $past(faults_in.bus_b_par_err, 3);
    endproperty
    a_bit2: assert property (p_bit2) else $error("bit 2 wrong");

    property p_bit3;
        @(posedge ref_clk) disable iff (!resetn)
        st_rd |=> rdata[3] == $past(faults_in.byte0_par_err, 3);
    endproperty
    a_bit3: assert property (p_bit3) else $error("bit 3 wrong");

    property p_bit4;
        @(posedge ref_clk) disable iff (!resetn)
        st_rd |=> rdata[4] == $past(faults_in.vn4p5_fault, 3);
    endproperty
    a_bit4: assert property (p_bit4) else $error("bit 4 wrong");

    property p_bit5;
        @(posedge ref_clk) disable iff (!resetn)
        st_rd |=> rdata[5] == $past(faults_in.v5p0_fault, 3);
    endproperty
    a_bit5: assert property (p_bit5) else $error("bit 5 wrong");

    property p_bit6;
        @(posedge ref_clk) disable iff (!resetn)
        st_rd |=> rdata[6] == $past(faults_in.single_bit_err, 3);
    endproperty
    a_bit6: assert property (p_bit6) else $error("bit 6 wrong");

    property p_bit7;
        @(posedge ref_clk) disable iff (!resetn)
        st_rd |=> rdata[7] == $past(faults_in.double_bit_err, 3);
    endproperty
    a_bit7: assert property (p_bit7) else $error("bit 7 wrong");

    property p_bit8;
        @(posedge ref_clk) disable iff (!resetn)
        st_rd |=> rdata[8] == $past(faults_in.head_sel_fault, 3);
    endproperty
    a_bit8: assert property (p_bit8) else $error("bit 8 wrong");

    property p_bit9;
        @(posedge ref_clk) disable iff (!resetn)
        st_rd |=> rdata[9] == $past(faults_in.off_cyl_fault, 3);
    endproperty
    a_bit9: assert property (p_bit9) else $error("bit 9 wrong");

    property p_bit10;
        @(posedge ref_clk) disable iff (!resetn)
        st_rd |=> rdata[10] == $past(faults_in.seek_fault, 3);
    endproperty
    a_bit10: assert property (p_bit10) else $error("bit 10 wrong");

    property p_bit11;
        @(posedge ref_clk) disable iff (!resetn)
        st_rd |=> rdata[11] == $past(faults_in.spindle_fault, 3);
    endproperty
    a_bit11: assert property (p_bit11) else $error("bit 11 wrong");

    property p_bit12;
        @(posedge ref_clk) disable iff (!resetn)
        st_rd |=> rdata[12] == $past(faults_in.exec_fault, 3);
    endproperty
    a_bit12: assert property (p_bit12) else $error("bit 12 wrong");

    property p_bit13;
        @(posedge ref_clk) disable iff (!resetn)
        st_rd |=> rdata[13] == $past(faults_in.id_ecc_err, 3);
    endproperty
    a_bit13: assert property (p_bit13) else $error("bit 13 wrong");

    property p_bit14;
        @(posedge ref_clk) disable iff (!resetn)
        st_rd |=> rdata[14] == $past(faults_in.id_compare_err, 3);
    endproperty
    a_bit14: assert property (p_bit14) else $error("bit 14 wrong");

    property p_bit15;
        @(posedge ref_clk) disable iff (!resetn)
        st_rd |=> rdata[15] == $past(faults_in.data_ecc_err, 3);
    endproperty
    a_bit15: assert property (p_bit15) else $error("bit 15 wrong");

    // A rising source edge leaves a sticky flag even if cleared that cycle
    property p_sticky;
        @(posedge ref_clk) disable iff (!resetn)
        (|rise) |=> ((state_reg.event_flags & $past(rise)) == $past(rise));
    endproperty
    a_sticky: assert property (p_sticky) else $error("event lost");

    // Status writes leave the mask unchanged
    property p_ro;
        @(posedge ref_clk) disable iff (!resetn)
        (bus_req.wr && hit_status) |=> state_reg.mask == $past(state_reg.mask);
    endproperty
    a_ro: assert property (p_ro) else $error("status write had effect");

    // Read data stand only in the cycle after a read
    property p_rd_idle;
        @(posedge ref_clk) disable iff (!resetn)
        !bus_req.rd |=> rdata == 16'h0000;
    endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data not cleared");

    // Interrupt follows unmasked sticky flags
    property p_irq;
        @(posedge ref_clk) disable iff (!resetn)
        irq == |(state_reg.event_flags & state_reg.mask);
    endproperty
    a_irq: assert property (p_irq) else $error("irq mismatch");

    // A cleared flag stays clear unless its source rose in that cycle
    property p_clear;
        @(posedge ref_clk) disable iff (!resetn)
        (bus_req.wr && hit_event) |=> (state_reg.event_flags & $past(w1c & ~rise)) == 16'h0000;
    endproperty
    a_clear: assert property (p_clear) else $error("flag survived clear");

    // No event flag appears without a rising source edge
    property p_no_spurious;
        @(posedge ref_clk) disable iff (!resetn)
        1'b1 |=> (state_reg.event_flags & ~$past(state_reg.event_flags | rise)) == 16'h0000;
    endproperty
    a_no_spurious: assert property (p_no_spurious) else $error("flag set without edge");

    // Mask takes the written word
    property p_mask_wr;
        @(posedge ref_clk) disable iff (!resetn)
        (bus_req.wr && hit_mask) |=> state_reg.mask == $past(bus_req.wdata);
    endproperty
    a_mask_wr: assert property (p_mask_wr) else $error("mask write lost");

    // Mask moves only on its own write
    property p_mask_hold;
        @(posedge ref_clk) disable iff (!resetn)
        !(bus_req.wr && hit_mask) |=> state_reg.mask == $past(state_reg.mask);
    endproperty
    a_mask_hold: assert property (p_mask_hold) else $error("mask changed");

    // Event reads return the flags as they stood at the strobe
    property p_rd_event;
        @(posedge ref_clk) disable iff (!resetn)
        (bus_req.rd && hit_event) |=> rdata == $past(state_reg.event_flags);
    endproperty
    a_rd_event: assert property (p_rd_event) else $error("event read wrong");

    // Mask reads return the mask as it stood at the strobe
    property p_rd_mask;
        @(posedge ref_clk) disable iff (!resetn)
        (bus_req.rd && hit_mask) |=> rdata == $past(state_reg.mask);
    endproperty
    a_rd_mask: assert property (p_rd_mask) else $error("mask read wrong");

    // Unmapped reads return zero so software sees no stale word
    property p_rd_unmapped;
        @(posedge ref_clk) disable iff (!resetn)
        (bus_req.rd && !(hit_status || hit_event || hit_mask)) |=> rdata == 16'h0000;
    endproperty
    a_rd_unmapped: assert property (p_rd_unmapped) else $error("unmapped read not zero");

    // Status reads show the whole synchronised word
    property p_rd_live;
        @(posedge ref_clk) disable iff (!resetn)
        st_rd |=> rdata == $past(live_word);
    endproperty
    a_rd_live: assert property (p_rd_live) else $error("status read wrong");

    // Every source reaches the word two edges after it is sampled
    property p_sync_lag;
        @(posedge ref_clk) disable iff (!resetn)
        $past(resetn, 2) |-> live_word == $past(raw_word, 2);
    endproperty
    a_sync_lag: assert property (p_sync_lag) else $error("word lags sources");

    // Status writes neither clear nor set event flags
    property p_ro_event;
        @(posedge ref_clk) disable iff (!resetn)
        (bus_req.wr && hit_status) |=>
            state_reg.event_flags == $past(state_reg.event_flags | rise);
    endproperty
    a_ro_event: assert property (p_ro_event) else $error("status write hit events");

    // A zero mask keeps the interrupt low
    property p_irq_masked;
        @(posedge ref_clk) disable iff (!resetn)
        (state_reg.mask == 16'h0000) |-> !irq;
    endproperty
    a_irq_masked: assert property (p_irq_masked) else $error("irq with zero mask");

    // The interrupt needs at least one sticky flag
    property p_irq_flag;
        @(posedge ref_clk) disable iff (!resetn)
        irq |-> state_reg.event_flags != 16'h0000;
    endproperty
    a_irq_flag: assert property (p_irq_flag) else $error("irq without flag");

endmodule // dafs_status

/* File: dafs_pkg.sv */
// Package for the disk adapter fault status word: offsets, reset values and carriers
package dafs_pkg;

    localparam int DATA_W = 16;
    localparam int ADDR_W = 8;

    // Register byte offsets
    localparam logic [7:0] OFF_STATUS = 8'h00;
    localparam logic [7:0] OFF_EVENT = 8'h04;
    localparam logic [7:0] OFF_MASK = 8'h08;

    // Values after reset
    localparam logic [15:0] RST_EVENT = 16'h0000;
    localparam logic [15:0] RST_MASK = 16'h0000;
    localparam logic [15:0] RST_WORD = 16'h0000;

    // Synchroniser depth in flip-flops
    localparam int SYNC_STAGES = 2;

    // Fault flags from the checking circuits and the drive; bit 0 is the last field
    typedef struct packed {
        logic data_ecc_err;
        logic id_compare_err;
        logic id_ecc_err;
        logic exec_fault;
        logic spindle_fault;
        logic seek_fault;
        logic off_cyl_fault;
        logic head_sel_fault;
        logic double_bit_err;
        logic single_bit_err;
        logic v5p0_fault;
        logic vn4p5_fault;
        logic byte0_par_err;
        logic bus_b_par_err;
        logic byte1_par_err;
        logic bus_a_par_err;
    } dafs_faults_t;

    // Register port request from the host side
    typedef struct packed {
        logic [7:0] addr;
        logic [15:0] wdata;
        logic wr;
        logic rd;
    } dafs_bus_req_t;

endpackage

/* File: dafs_sync.sv */
// Two-flop synchroniser for a vector of asynchronous fault levels
`timescale 1ns/1ps

module dafs_sync #(
    parameter int W = 16
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic resetn,
    // Asynchronous levels in, synchronised levels out
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);

    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] stable;
    } dafs_sync_state_t;

    dafs_sync_state_t state_reg;
    dafs_sync_state_t state_next;

    // Only the second stage is visible; the first stage feeds nothing else
    always_comb
    begin
        state_next = state_reg;
        state_next.meta = async_in;
        state_next.stable = state_reg.meta;
    end

    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            state_reg <= '0;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    assign sync_out = state_reg.stable;

endmodule // dafs_sync

/* File: dafs_fault_src.sv */
// Behavioural model of the drive and checking circuits that raise fault levels
`timescale 1ns/1ps

module dafs_fault_src (
    // Requested levels and how late they appear, in ns
    input wire logic [15:0] want,
    input wire logic [2:0] lag_ns,
    // Fault levels toward the adapter
    output dafs_pkg::dafs_faults_t faults
);
    initial
    begin
        faults = '0;
    end

    // Levels move off the clock edge, as real asynchronous sources do
    always @(want)
    begin
        faults <= #(lag_ns) dafs_pkg::dafs_faults_t'(want);
    end
endmodule // dafs_fault_src

/* File: tb_dafs_status.sv */
// Self-checking testbench for the combined fault status word
`timescale 1ns/1ps

module tb_dafs_status;
    logic ref_clk;
    logic resetn;
    dafs_pkg::dafs_bus_req_t bus_req;
    dafs_pkg::dafs_faults_t faults;
    logic [15:0] rdata;
    logic irq;
    logic [15:0] want;
    logic [2:0] lag_ns;
    logic [15:0] exp_q[$];
    logic [15:0] exp_v;
    logic [15:0] pat;
    logic rd_d;
    int err_total = 0;
    int comparisons = 0;
    int cycles = 0;

    dafs_fault_src u_src (.want(want), .lag_ns(lag_ns), .faults(faults));

    dafs_status u_dut (
        .ref_clk(ref_clk),
        .resetn(resetn),
        .faults_in(faults),
        .bus_req(bus_req),
        .rdata(rdata),
        .irq(irq)
    );

    initial
    begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end

    task automatic compare(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            err_total++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic reg_wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge ref_clk);
        bus_req.addr <= a;
        bus_req.wdata <= d;
        bus_req.wr <= 1'b1;
        @(posedge ref_clk);
        bus_req.wr <= 1'b0;
    endtask

    // The expected word is queued here and judged by the watcher below
    task automatic reg_rd(input logic [7:0] a, input logic [15:0] e);
        @(posedge ref_clk);
        bus_req.addr <= a;
        bus_req.rd <= 1'b1;
        exp_q.push_back(e);
        @(posedge ref_clk);
        bus_req.rd <= 1'b0;
    endtask

    // Six edges cover the random lag, the two sync flops and the event latch
    task automatic set_faults(input logic [15:0] v);
        want <= v;
        lag_ns <= 3'($urandom_range(7, 0));
        repeat (6) @(posedge ref_clk);
    endtask

    task automatic check_irq(input logic e);
        repeat (2) @(negedge ref_clk);
        compare({15'h0000, irq}, {15'h0000, e});
    endtask

    // Read data stand only in the cycle after the strobe
    always @(posedge ref_clk)
    begin
        cycles++;
        if (rd_d === 1'b1 && exp_q.size() > 0)
        begin
            exp_v = exp_q.pop_front();
            compare(rdata, exp_v);
        end
        rd_d <= bus_req.rd;
        if (cycles == 20000)
        begin
            err_total++;
            print_verdict();
        end
    end

    initial
    begin
        resetn = 1'b0;
        bus_req = '0;
        want = '0;
        lag_ns = '0;
        void'($urandom(32'h8D96));
        repeat (12) @(posedge ref_clk);
        resetn <= 1'b1;
        reg_rd(dafs_pkg::OFF_STATUS, dafs_pkg::RST_WORD);
        reg_rd(dafs_pkg::OFF_EVENT, dafs_pkg::RST_EVENT);
        reg_rd(dafs_pkg::OFF_MASK, dafs_pkg::RST_MASK);
        reg_rd(8'h0C, 16'h0000);
        check_irq(1'b0);
        $display("test reset values done");
        for (int i = 0; i < 16; i++)
        begin
            set_faults(16'h0001 << i);
            reg_rd(dafs_pkg::OFF_STATUS, 16'h0001 << i); // to by bit index
        end
        $display("test single fault bits done");
        repeat (8)
        begin
            pat = 16'($urandom);
            set_faults(pat);
            reg_wr(dafs_pkg::OFF_STATUS, ~pat);
            reg_rd(dafs_pkg::OFF_STATUS, pat);
        end
        $display("test random words done");
        set_faults(16'h0000);
        reg_wr(dafs_pkg::OFF_EVENT, 16'hFFFF);
        reg_wr(dafs_pkg::OFF_MASK, 16'h0100);
        check_irq(1'b0);
        set_faults(16'h0101);
        check_irq(1'b1);
        reg_rd(dafs_pkg::OFF_EVENT, 16'h0101);
        reg_rd(dafs_pkg::OFF_MASK, 16'h0100);
        reg_wr(dafs_pkg::OFF_MASK, 16'h0000);
        check_irq(1'b0);
        reg_wr(dafs_pkg::OFF_MASK, 16'h0100);
        check_irq(1'b1);
        reg_wr(dafs_pkg::OFF_EVENT, 16'h0100);
        check_irq(1'b0);
        reg_rd(dafs_pkg::OFF_EVENT, 16'h0001);
        reg_wr(8'h0C, 16'hFFFF);
        reg_rd(dafs_pkg::OFF_STATUS, 16'h0101);
        repeat (3) @(posedge ref_clk);
        $display("test interrupt done");
        // Zero lag lets the clear land in the cycle of a new edge on bit 1
        lag_ns <= 3'h0;
        @(posedge ref_clk);
        want <= 16'h0103;
        @(posedge ref_clk);
        reg_wr(dafs_pkg::OFF_EVENT, 16'h0003);
        reg_rd(dafs_pkg::OFF_EVENT, 16'h0002);
        reg_wr(dafs_pkg::OFF_MASK, 16'hFFFF);
        check_irq(1'b1);
        $display("test set against clear done");
        set_faults(16'h0000);
        resetn <= 1'b0;
        check_irq(1'b0);
        @(posedge ref_clk);
        resetn <= 1'b1;
        reg_rd(dafs_pkg::OFF_EVENT, dafs_pkg::RST_EVENT);
        reg_rd(dafs_pkg::OFF_MASK, dafs_pkg::RST_MASK);
        reg_rd(dafs_pkg::OFF_STATUS, dafs_pkg::RST_WORD);
        check_irq(1'b0);
        $display("test reset in mid-run done");
        repeat (3) @(posedge ref_clk);
        print_verdict();
    end
endmodule // tb_dafs_status
